// ### include/atlb_pkg.sv
// Shared constants and types of the address mapping and translation unit.
// Assumes one core clock; the table walk is served by the memory interface.
package atlb_pkg;
    // ==========================================================
    // Register map (APB byte addresses)
    localparam logic [7:0]  ADDR_CFG   = 8'h00;
    localparam logic [7:0]  ADDR_FCW   = 8'h04;
    localparam logic [7:0]  ADDR_STAT  = 8'h08;
    localparam int          CFG_SX_BIT = 0;
    localparam int          CFG_NX_BIT = 1;
    localparam int          FCW_SN_BIT = 14;
    localparam int          FCW_EC_BIT = 13;
    localparam int          FCW_LS_BIT = 12;
    localparam logic [15:0] FCW_RST    = 16'h4000;
    localparam logic [1:0]  CFG_RST    = 2'h0;
    // ==========================================================
    // Page and walk layout
    localparam int          TLB_N      = 16;
    localparam int          PAGE_W     = 22;
    localparam int          OFS_W      = 10;
    localparam int          PTE_V_BIT  = 0;
    localparam int          PTE_IO_BIT = 1;
    localparam int          PTE_PROT_LO = 2;
    localparam int          PTE_NC_BIT = 6;
    localparam int          PTE_M_BIT  = 7;
    // Access rights {read, write, execute} per protection code
    localparam logic [2:0] PROT_SYS [16] = '{3'h0, 3'h5, 3'h5, 3'h5, 3'h1, 3'h1, 3'h4, 3'h4,
                                             3'h0, 3'h6, 3'h6, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
    localparam logic [2:0] PROT_NRM [16] = '{3'h0, 3'h0, 3'h1, 3'h5, 3'h0, 3'h1, 3'h0, 3'h4,
                                             3'h0, 3'h0, 3'h4, 3'h6, 3'h0, 3'h1, 3'h5, 3'h7};
    // ==========================================================
    // Types
    typedef enum logic [1:0] {ACC_IFETCH, ACC_IMM, ACC_REL, ACC_DATA} atlb_acc_t;
    typedef enum logic [2:0] {FLT_NONE, FLT_ODD_PC, FLT_NO_MAP, FLT_PROT, FLT_REP} atlb_flt_t;
    typedef struct packed {
        logic        io;
        atlb_acc_t   acc;
        logic        write;
        logic [31:0] pc;
        logic [31:0] base;
        logic [31:0] calc;
    } atlb_req_t;
    typedef struct packed {
        logic [31:0] paddr;
        logic        io;
        logic        cacheable;
        logic [1:0]  space;
        atlb_flt_t   fault;
    } atlb_rsp_t;
    typedef struct packed {
        logic [1:0] space;
        logic [7:0] l1;
        logic [7:0] l2;
        logic [5:0] pidx;
    } atlb_walk_t;
    typedef struct packed {
        logic        valid;
        logic [23:0] tag;
        logic [21:0] frame;
        logic        io;
        logic [3:0]  prot;
        logic        nc;
        logic        m;
    } atlb_entry_t;
endpackage

// ### core/atlb_core.sv
// Logical to physical address mapping with a 16-entry translation buffer.
// Assumes requests come from logic on pclk; walk answers on pclk.
`timescale 1ns/10ps
// How it works
// - System mode uses system spaces, normal uses normal
// - Fetch, immediate, relative go to instruction space
// - Other operand accesses go to data space
// - Compact address takes upper half from PC
// - Segmented: small and large segments by top bit
// - Lowest byte address is most significant byte
// - Any operand alignment allowed without fault
// - Instruction fetch at odd address traps
// - I/O address upper 16 bits forced zero
// - I/O addresses pass untranslated
// - I/O locations never cacheable
// - Translation may map memory to memory or I/O
// - 1K pages, low 10 bits pass unchanged
// - Per-mode enable bits; disabled means identity, full access
// - 16 entries, fully associative tag compare
// - Hit supplies frame address for physical address
// - Miss walks tables, replaces least recently used
// - 24-bit tags: page plus space bits
// - Entries hold protection, non-cacheable, modified
// - Check fetch, read, write rights of current mode
// - Missing mapping raises restartable fault
// - Two control bits choose address representation
// - Privilege bit 1 system, 0 normal
// - Walk splits address 8, 8, 6, 10 bits
module atlb_core
    import atlb_pkg::*;
(
    input  wire logic        pclk,      // Core clock
    input  wire logic        presetn,   // Async reset, active low
    input  wire logic        ce,        // Clock enable, freezes state
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB enable
    input  wire logic        pwrite,    // APB direction
    input  wire logic [31:0] paddr,     // APB address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error
    input  wire logic        req_valid, // Reference request
    input  atlb_req_t        req,       // Reference details
    output logic             req_ready, // Request taken
    output logic             rsp_valid, // Answer pulse
    output atlb_rsp_t        rsp,       // Answer details
    output logic             walk_valid, // Table walk request
    output atlb_walk_t       walk,      // Walk indices
    input  wire logic        walk_ack,  // Walk result valid
    input  wire logic [31:0] walk_pte   // Page table entry
);
    typedef enum logic {ST_IDLE, ST_WALK} atlb_st_t;
    typedef struct packed {
        logic [1:0]                xlate_en;
        logic [15:0]               flag_control_word;
        atlb_st_t                  st;
        atlb_req_t                 held;
        logic [1:0]                hspace;
        logic [31:0]               hladdr;
        atlb_entry_t [TLB_N-1:0]   tlb;
        logic [TLB_N-1:0][3:0]     age;
        logic                      rsp_valid;
        atlb_rsp_t                 rsp;
        logic                      walk_valid;
        atlb_walk_t                walk;
        atlb_flt_t                 last_flt;
    } atlb_state_t;

    atlb_state_t r;
    atlb_state_t next_r;
    logic        accept;
    logic        wr_acc;
    logic        sys;
    logic [1:0]  space;
    logic [31:0] laddr;
    logic        rep_bad;
    logic        hit;
    logic [3:0]  hidx;
    logic [3:0]  vidx;
    atlb_entry_t fill;

    // ==========================================================
    // Helpers
    function automatic atlb_rsp_t f_resolve(atlb_entry_t e, logic [31:0] la,
                                            atlb_req_t q, logic s, logic [1:0] sp);
        atlb_rsp_t   o;
        logic [2:0]  rt;
        logic [2:0]  need;
        rt   = s ? PROT_SYS[e.prot] : PROT_NRM[e.prot];
        need = (q.acc == ACC_IFETCH || q.acc == ACC_IMM) ? 3'h1 : (q.write ? 3'h2 : 3'h4);
        o.paddr     = {e.frame, la[OFS_W-1:0]};
        o.io        = e.io;
        o.cacheable = !e.io && !e.nc;
        o.space     = sp;
        o.fault     = ((rt & need) == 3'h0) ? FLT_PROT : FLT_NONE;
        return o;
    endfunction

    function automatic logic [TLB_N-1:0][3:0] f_touch(logic [TLB_N-1:0][3:0] a,
                                                      logic [3:0] k);
        logic [TLB_N-1:0][3:0] o;
        o = a;
        for (int i = 0; i < TLB_N; i++) begin
            if (a[i] < a[k]) begin
                o[i] = a[i] + 4'h1;
            end
        end
        o[k] = 4'h0;
        return o;
    endfunction

    // ==========================================================
    // Address formation and lookup
    assign accept = req_valid && req_ready;
    assign sys    = r.flag_control_word[FCW_SN_BIT];
    assign space  = {sys, req.acc != ACC_DATA};

    // Bytes are big-endian in memory; operand alignment is never checked.
    always_comb begin
        rep_bad = 1'b0;
        laddr   = req.calc;
        if (req.io) begin
            laddr = {16'h0000, req.calc[15:0]};
        end else begin
            unique case ({r.flag_control_word[FCW_EC_BIT], r.flag_control_word[FCW_LS_BIT]})
                2'b00: laddr = {req.pc[31:16], req.calc[15:0]};
                2'b01: rep_bad = 1'b1;
                2'b10: laddr = req.base[31] ? {req.base[31:24], req.calc[23:0]}
                                            : {req.base[31:16], req.calc[15:0]};
                2'b11: laddr = req.calc;
            endcase
        end
    end

    always_comb begin
        hit  = 1'b0;
        hidx = 4'h0;
        vidx = 4'h0;
        for (int i = 0; i < TLB_N; i++) begin
            if (r.tlb[i].valid && r.tlb[i].tag == {space, laddr[31:OFS_W]}) begin
                hit  = 1'b1;
                hidx = 4'(i);
            end
            if (r.age[i] == 4'hf) begin
                vidx = 4'(i);
            end
        end
    end

    always_comb begin
        fill.valid = 1'b1;
        fill.tag   = {r.hspace, r.hladdr[31:OFS_W]};
        fill.frame = walk_pte[31:OFS_W];
        fill.io    = walk_pte[PTE_IO_BIT];
        fill.prot  = walk_pte[PTE_PROT_LO +: 4];
        fill.nc    = walk_pte[PTE_NC_BIT];
        fill.m     = walk_pte[PTE_M_BIT];
    end

    // ==========================================================
    // Next state
    assign wr_acc = psel && penable && pwrite && ce;

    always_comb begin
        next_r           = r;
        next_r.rsp_valid = 1'b0;
        if (wr_acc && paddr[7:0] == ADDR_CFG) begin
            next_r.xlate_en = pwdata[1:0];
        end
        if (wr_acc && paddr[7:0] == ADDR_FCW) begin
            next_r.flag_control_word = pwdata[15:0];
        end
        unique case (r.st)
            ST_IDLE: begin
                if (accept) begin
                    next_r.rsp_valid  = 1'b1;
                    next_r.held       = req;
                    next_r.hspace     = space;
                    next_r.hladdr     = laddr;
                    next_r.rsp.paddr  = laddr;
                    next_r.rsp.space  = space;
                    next_r.rsp.fault  = FLT_NONE;
                    next_r.rsp.io     = req.io;
                    next_r.rsp.cacheable = !req.io;
                    if (req.io) begin
                        next_r.rsp.cacheable = 1'b0;
                    end else if (rep_bad) begin
                        next_r.rsp.fault = FLT_REP;
                    end else if (req.acc == ACC_IFETCH && laddr[0]) begin
                        next_r.rsp.fault = FLT_ODD_PC;
                    end else if (!r.xlate_en[sys ? CFG_SX_BIT : CFG_NX_BIT]) begin
                        next_r.rsp.cacheable = 1'b1;
                    end else if (hit) begin
                        next_r.rsp = f_resolve(r.tlb[hidx], laddr, req, sys, space);
                        next_r.age = f_touch(r.age, hidx);
                    end else begin
                        next_r.rsp_valid  = 1'b0;
                        next_r.st         = ST_WALK;
                        next_r.walk_valid = 1'b1;
                        next_r.walk       = {space, laddr[31:24], laddr[23:16],
                                             laddr[15:10]};
                    end
                    next_r.last_flt = next_r.rsp.fault;
                end
            end
            ST_WALK: begin
                if (walk_ack) begin
                    next_r.walk_valid = 1'b0;
                    next_r.st         = ST_IDLE;
                    next_r.rsp_valid  = 1'b1;
                    next_r.rsp.space  = r.hspace;
                    next_r.rsp.paddr  = r.hladdr;
                    next_r.rsp.io     = 1'b0;
                    next_r.rsp.cacheable = 1'b0;
                    next_r.rsp.fault  = FLT_NO_MAP;
                    if (walk_pte[PTE_V_BIT]) begin
                        next_r.tlb[vidx] = fill;
                        next_r.age       = f_touch(r.age, vidx);
                        next_r.rsp = f_resolve(fill, r.hladdr, r.held, r.hspace[1], r.hspace);
                    end
                    next_r.last_flt = next_r.rsp.fault;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.flag_control_word      <= FCW_RST;
            r.xlate_en <= CFG_RST;
            for (int i = 0; i < TLB_N; i++) begin
                r.age[i] <= 4'(i);
            end
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs and APB read side
    assign req_ready  = ce && (r.st == ST_IDLE);
    assign rsp_valid  = r.rsp_valid;
    assign rsp        = r.rsp;
    assign walk_valid = r.walk_valid;
    assign walk       = r.walk;
    assign pready     = ce;

    always_comb begin
        prdata  = 32'h0;
        pslverr = 1'b0;
        unique case (paddr[7:0])
            ADDR_CFG:  prdata = {30'h0, r.xlate_en};
            ADDR_FCW:  prdata = {16'h0, r.flag_control_word};
            ADDR_STAT: prdata = {28'h0, r.last_flt, r.st == ST_WALK};
            default:   pslverr = psel && penable;
        endcase
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take_io;
        accept && req.io;
    endsequence
    sequence s_io_answer;
        rsp_valid && rsp.io && rsp.paddr[31:16] == 16'h0 && !rsp.cacheable;
    endsequence
    property p_io_pass;
        s_take_io |=> s_io_answer
            and (rsp.paddr[15:0] == $past(req.calc[15:0]));
    endproperty
    a_io_pass: assert property (p_io_pass) else $error("io address altered");

    property p_io_nocache;
        rsp_valid && rsp.io |-> !rsp.cacheable;
    endproperty
    a_io_nocache: assert property (p_io_nocache) else $error("io cacheable");

    property p_offset;
        rsp_valid && rsp.fault == FLT_NONE |-> rsp.paddr[9:0] == r.hladdr[9:0];
    endproperty
    a_offset: assert property (p_offset) else $error("page offset changed");

    property p_odd_pc;
        accept && !req.io && !rep_bad && req.acc == ACC_IFETCH && laddr[0]
            |=> rsp_valid && rsp.fault == FLT_ODD_PC;
    endproperty
    a_odd_pc: assert property (p_odd_pc) else $error("odd pc not trapped");

    property p_space;
        accept && !req.io |=> r.hspace == {$past(r.flag_control_word[FCW_SN_BIT]), $past(req.acc) != ACC_DATA};
    endproperty
    a_space: assert property (p_space) else $error("wrong space");

    property p_compact;
        accept && !req.io && r.flag_control_word[FCW_EC_BIT:FCW_LS_BIT] == 2'b00
            |=> r.hladdr == {$past(req.pc[31:16]), $past(req.calc[15:0])};
    endproperty
    a_compact: assert property (p_compact) else $error("compact address wrong");

    property p_bypass;
        accept && !req.io && !rep_bad && !(req.acc == ACC_IFETCH && laddr[0])
            && !r.xlate_en[sys ? CFG_SX_BIT : CFG_NX_BIT]
            |=> rsp_valid && rsp.paddr == r.hladdr && rsp.fault == FLT_NONE;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not identity");

    property p_instr_space;
        accept && !req.io && req.acc != ACC_DATA |=> r.hspace[0];
    endproperty
    a_instr_space: assert property (p_instr_space) else $error("not instruction space");

    sequence s_miss;
        accept && !req.io && !rep_bad && !(req.acc == ACC_IFETCH && laddr[0])
            && r.xlate_en[sys ? CFG_SX_BIT : CFG_NX_BIT] && !hit;
    endsequence
    property p_walk_start;
        s_miss |=> walk_valid && !rsp_valid && walk == $past({space, laddr[31:OFS_W]});
    endproperty
    a_walk_start: assert property (p_walk_start) else $error("no walk on miss");

    property p_walk_hold;
        walk_valid && !walk_ack |=> walk_valid && $stable(walk) && !req_ready;
    endproperty
    a_walk_hold: assert property (p_walk_hold) else $error("walk request dropped");

    sequence s_walk_done;
        walk_valid && walk_ack && ce;
    endsequence
    // A hit taken right after the walk may answer again at once
    sequence s_walk_answer;
        (rsp_valid && !walk_valid && (req_ready || !ce))
            ##1 (!rsp_valid || $past(accept) || !$past(ce));
    endsequence
    property p_walk_end;
        s_walk_done |=> s_walk_answer;
    endproperty
    a_walk_end: assert property (p_walk_end) else $error("walk not answered");
endmodule // atlb_core

// ### verif/atlb_walk_model.sv
// Memory interface model that answers table walks of the translation unit.
// Assumes the bench sets the entry to return and the answer delay.
`timescale 1ns/10ps
module atlb_walk_model
    import atlb_pkg::*;
(
    input  wire logic        pclk,       // Core clock
    input  wire logic        presetn,    // Async reset, active low
    input  wire logic        walk_valid, // Walk request from the unit
    input  atlb_walk_t       walk,       // Walk indices
    input  wire logic [3:0]  delay,      // Cycles before the answer
    input  wire logic [31:0] pte_val,    // Entry handed back
    output logic             walk_ack,   // Answer pulse
    output logic      [31:0] walk_pte,   // Entry, valid with walk_ack only
    output logic      [31:0] walks       // Number of walks answered
);
    logic [3:0] cnt;

    // ==========================================================
    // Answer after the delay; the data lines toggle outside the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 4'h0;
            walk_ack <= 1'b0;
            walk_pte <= 32'h0;
            walks    <= 32'h0;
        end else begin
            walk_ack <= 1'b0;
            walk_pte <= ~walk_pte;
            if (walk_valid && !walk_ack) begin
                if (cnt == delay) begin
                    walk_ack <= 1'b1;
                    walk_pte <= pte_val;
                    cnt      <= 4'h0;
                    walks    <= walks + 32'h1;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule // atlb_walk_model

// ### verif/atlb_core_tb.sv
// Self-checking bench of the address mapping and translation unit.
// Assumes the walk model answers every table walk; ce is held high.
`timescale 1ns/10ps
module atlb_core_tb;
    import atlb_pkg::*;
    logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic        req_valid = 0, pready, pslverr, err, req_ready, rsp_valid;
    logic        walk_valid, walk_ack;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd, walk_pte, pte = 0, walks, ew;
    logic [3:0]  dly = 1;
    atlb_req_t   req = '0;
    atlb_rsp_t   rsp;
    atlb_walk_t  walk, wk;
    int          miscompares = 0, checked = 0;

    always #2.5 pclk = ~pclk;

    atlb_core uut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .req_valid, .req, .req_ready, .rsp_valid, .rsp,
        .walk_valid, .walk, .walk_ack, .walk_pte);
    atlb_walk_model mem (.pclk, .presetn, .walk_valid, .walk, .delay(dly),
        .pte_val(pte), .walk_ack, .walk_pte, .walks);

    // ==========================================================
    // Shared tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d; penable <= 0;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask

    // One reference with a fixed program counter; waits for its answer
    task automatic q(input logic i, input atlb_acc_t a, input logic w,
                     input logic [31:0] b, input logic [31:0] c);
        int n;
        @(posedge pclk);
        req <= '{i, a, w, 32'habcd0102, b, c}; req_valid <= 1;
        do begin
            @(posedge pclk);
        end while (req_ready !== 1'b1);
        req_valid <= 0;
        n = 0;
        do begin
            @(negedge pclk); n++;
            if (walk_valid === 1'b1) wk = walk;
        end while (rsp_valid !== 1'b1 && n < 50);
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    endtask

    task automatic rc(input logic [31:0] p, input atlb_flt_t f, input logic [1:0] s);
        chk("paddr", p, rsp.paddr);
        chk("fault", {29'h0, f}, {29'h0, rsp.fault});
        chk("space", {30'h0, s}, {30'h0, rsp.space});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs;
        chk("walk_valid", 32'h0, {31'h0, walk_valid});
        apb(0, 8'h04, 0); chk("fcw", 32'h4000, rd);
        apb(0, 8'h00, 0); chk("cfg", 32'h0, rd);
        apb(0, 8'h40, 0); chk("slverr", 32'h1, {31'h0, err});
        apb(1, 8'h04, 32'h3000); apb(0, 8'h04, 0); chk("fcw", 32'h3000, rd);
    endtask

    task automatic t_bypass;
        apb(1, 8'h04, 32'h4000);
        q(0, ACC_DATA, 0, 0, 32'h5679); rc(32'habcd5679, FLT_NONE, 2'b10);
        q(0, ACC_IMM, 0, 0, 32'h5678); rc(32'habcd5678, FLT_NONE, 2'b11);
        q(0, ACC_REL, 0, 0, 32'h5678); rc(32'habcd5678, FLT_NONE, 2'b11);
        q(0, ACC_IFETCH, 0, 0, 32'h5679); chk("fault", 1, {29'h0, rsp.fault});
        apb(1, 8'h04, 32'h6000);
        q(0, ACC_DATA, 0, 32'h81230000, 32'h456789); rc(32'h81456789, FLT_NONE, 2'b10);
        q(0, ACC_DATA, 0, 32'h00070000, 32'h456789); rc(32'h00076789, FLT_NONE, 2'b10);
        apb(1, 8'h04, 32'h1000);
        q(0, ACC_DATA, 0, 0, 32'h5678); chk("fault", 4, {29'h0, rsp.fault});
        apb(0, 8'h08, 0); chk("stat", 32'h8, rd);
        apb(1, 8'h04, 32'h3000);
        q(0, ACC_DATA, 0, 0, 32'h12345678); rc(32'h12345678, FLT_NONE, 2'b00);
        q(0, ACC_IMM, 0, 0, 32'h12345678); rc(32'h12345678, FLT_NONE, 2'b01);
    endtask

    task automatic t_xlate;
        apb(1, 8'h00, 1); apb(1, 8'h04, 32'h7000);
        pte = {22'h0abcd, 10'h03d}; dly = 7; ew = 1;
        q(0, ACC_DATA, 0, 0, 32'h12345678); rc({22'h0abcd, 10'h278}, FLT_NONE, 2'b10);
        chk("walks", ew, walks);
        chk("walk", {8'h0, 2'b10, 8'h12, 8'h34, 6'h15}, {8'h0, wk});
        chk("cacheable", 1, {31'h0, rsp.cacheable});
        dly = 1;
        q(0, ACC_DATA, 1, 0, 32'h123457fe); rc({22'h0abcd, 10'h3fe}, FLT_NONE, 2'b10);
        chk("walks", ew, walks);
        q(0, ACC_IFETCH, 0, 0, 32'h12345601); chk("fault", 1, {29'h0, rsp.fault});
        q(1, ACC_DATA, 0, 0, 32'hffff1234); chk("paddr", 32'h1234, rsp.paddr);
        chk("io", 1, {31'h0, rsp.io}); chk("cacheable", 0, {31'h0, rsp.cacheable});
        chk("walks", ew, walks);
        pte = 0; ew++;
        q(0, ACC_DATA, 0, 0, 32'h400); chk("fault", 2, {29'h0, rsp.fault});
        pte = 32'h1; ew++;
        q(0, ACC_DATA, 0, 0, 32'h800); chk("fault", 3, {29'h0, rsp.fault});
        pte = {22'h1, 10'h03f}; ew++;
        q(0, ACC_DATA, 0, 0, 32'hc04); chk("paddr", {22'h1, 10'h004}, rsp.paddr);
        chk("io", 1, {31'h0, rsp.io}); chk("cacheable", 0, {31'h0, rsp.cacheable});
        pte = {22'h2, 10'h03d};
        for (int i = 1; i <= 16; i++) q(0, ACC_DATA, 0, 0, i << 20);
        ew += 16; chk("walks", ew, walks);
        q(0, ACC_DATA, 0, 0, 32'h01000010); chk("walks", ew, walks);
        q(0, ACC_DATA, 0, 0, 32'h12345678); ew++; chk("walks", ew, walks);
        apb(1, 8'h00, 3); apb(1, 8'h04, 32'h3000);
        q(0, ACC_DATA, 0, 0, 32'h01000010); rc({22'h2, 10'h010}, FLT_NONE, 2'b00);
        ew++; chk("walks", ew, walks);
        apb(1, 8'h00, 1);
        q(0, ACC_DATA, 0, 0, 32'h00f00123); rc(32'h00f00123, FLT_NONE, 2'b00);
        chk("walks", ew, walks);
    endtask

    // Reset in mid-run must restore the flag word and forget the walk count
    task automatic t_reset;
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        chk("walk_valid", 32'h0, {31'h0, walk_valid});
        apb(0, 8'h04, 0); chk("fcw", 32'h4000, rd);
        apb(1, 8'h00, 1);
        q(0, ACC_DATA, 0, 0, 32'h12345678); rc({22'h2, 10'h278}, FLT_NONE, 2'b10);
        ew = 1; chk("walks", ew, walks);
    endtask

    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_bypass;
        t_xlate;
        t_reset;
        wrap_up;
    end

    initial begin
        #100000;
        miscompares++;
        wrap_up;
    end
endmodule // atlb_core_tb
